// >>> common/pwmos_defines.svh
// register map, field positions, reset values and timing for the pwm output stage
`ifndef PWMOS_DEFINES_SVH
`define PWMOS_DEFINES_SVH

`define PWMOS_ADDR_IOCTL      4'h0
`define PWMOS_ADDR_TBCTL      4'h4
`define PWMOS_ADDR_PERIOD     4'h8
`define PWMOS_ADDR_DUTY       4'hC

`define PWMOS_BIT_HIGH_OWNER  15
`define PWMOS_BIT_LOW_OWNER   14
`define PWMOS_BIT_HIGH_OVR    9
`define PWMOS_BIT_LOW_OVR     8
`define PWMOS_BIT_OVR_HIGH    1
`define PWMOS_BIT_OVR_LOW     0
`define PWMOS_BIT_ENABLE      15
`define PWMOS_BIT_EXT_RST_EN  0
`define PWMOS_BIT_RUNNING     14

`define PWMOS_IOCTL_RESET     16'h0000
`define PWMOS_TBCTL_RESET     16'h0000
`define PWMOS_PERIOD_RESET    16'h0064
`define PWMOS_DUTY_RESET      16'h0032

`define PWMOS_SYNC_NS         100
`define PWMOS_CLK_NS          20
`define PWMOS_SYNC_CYCLES     ((`PWMOS_SYNC_NS + `PWMOS_CLK_NS - 1) / `PWMOS_CLK_NS)

`define PWMOS_RESP_OKAY       2'b00
`define PWMOS_RESP_SLVERR     2'b10

`endif

// >>> common/pwmos_pkg.sv
// types shared by the pwm output stage
package pwmos_pkg;
  typedef logic [15:0] pwmos_word_t;
  typedef enum logic [1:0] {PWMOS_PHASE_ON, PWMOS_PHASE_OFF} pwmos_phase_t;
endpackage

// >>> common/pwmos_tb_if.sv
// time-base signals between the register top and the counter
`timescale 1ns/1ps
interface pwmos_tb_if;
  import pwmos_pkg::*;
  logic        enable;
  logic        ext_rst_en;
  logic        ext_rst;
  pwmos_word_t period;
  pwmos_word_t duty;
  logic        wave;
  logic        sync_pulse;
  logic        running;
  modport ctrl
  (
    output enable, ext_rst_en, ext_rst, period, duty,
    input  wave, sync_pulse, running
  );
  modport gen
  (
    input  enable, ext_rst_en, ext_rst, period, duty,
    output wave, sync_pulse, running
  );
endinterface

// >>> design/pwmos_timebase.sv
// pwm time base: counter, waveform, external period reset and sync pulse
`timescale 1ns/1ps
`include "pwmos_defines.svh"
module pwmos_timebase
  import pwmos_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  pwmos_tb_if.gen   tb
);
  pwmos_word_t  count;
  pwmos_word_t  next_count;
  logic         armed;
  logic         next_armed;
  logic         wave;
  logic         next_wave;
  logic         sync_q;
  logic         next_sync_q;
  logic [3:0]   sync_cnt;
  logic [3:0]   next_sync_cnt;
  pwmos_phase_t phase;

  assign phase = (count < tb.duty) ? PWMOS_PHASE_ON : PWMOS_PHASE_OFF;

  // ==========================================================
  // next state
  always_comb
  begin
    next_count    = count;
    next_armed    = armed;
    next_wave     = 1'b0;
    next_sync_q   = 1'b0;
    next_sync_cnt = sync_cnt;
    if (!tb.enable)
    begin
      next_count    = 16'h0000;
      next_armed    = 1'b0;
      next_sync_cnt = 4'h0;
    end
    else
    begin
      // a request is only honoured if it first appears in the off part;
      // one held through the on part stays disarmed until released
      if (!tb.ext_rst || phase == PWMOS_PHASE_ON)
        next_armed = 1'b1;
      if (!tb.ext_rst && phase == PWMOS_PHASE_ON)
        next_armed = 1'b1;
      if (tb.ext_rst && phase == PWMOS_PHASE_ON)
        next_armed = 1'b0;
      if (tb.ext_rst_en && tb.ext_rst && armed && phase == PWMOS_PHASE_OFF)
      begin
        next_count = 16'h0000;
        next_armed = 1'b0;
      end
      else if (count >= tb.period)
        next_count = 16'h0000;
      else
        next_count = count + 16'h0001;
      next_wave = (next_count < tb.duty);
      if (next_count == 16'h0000)
        next_sync_cnt = 4'(`PWMOS_SYNC_CYCLES);
      else if (sync_cnt != 4'h0)
        next_sync_cnt = sync_cnt - 4'h1;
      next_sync_q = (next_sync_cnt != 4'h0);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count    <= 16'h0000;
      armed    <= 1'b0;
      wave     <= 1'b0;
      sync_q   <= 1'b0;
      sync_cnt <= 4'h0;
    end
    else
    begin
      count    <= next_count;
      armed    <= next_armed;
      wave     <= next_wave;
      sync_q   <= next_sync_q;
      sync_cnt <= next_sync_cnt;
    end
  end

  assign tb.wave       = wave;
  assign tb.sync_pulse = sync_q;
  assign tb.running    = tb.enable;
endmodule

// >>> design/pwmos_top.sv
// pwm output stage: axi4-lite registers, pin ownership, override and sync output
//
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "pwmos_defines.svh"
module pwmos_top
  import pwmos_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RESET_N,
  input  wire logic [3:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [3:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic        EXT_PERIOD_RESET,
  input  wire logic        GPIO_HIGH_OUT,
  input  wire logic        GPIO_LOW_OUT,
  output logic             PWM_HIGH_OUTPUT,
  output logic             PWM_LOW_OUTPUT,
  output logic             SECONDARY_SYNC_OUTPUT
);
  pwmos_tb_if  tbi ();

  pwmos_word_t ioctl;
  pwmos_word_t next_ioctl;
  pwmos_word_t tbctl;
  pwmos_word_t next_tbctl;
  pwmos_word_t period;
  pwmos_word_t next_period;
  pwmos_word_t duty;
  pwmos_word_t next_duty;
  logic [3:0]  aw_addr;
  logic [3:0]  next_aw_addr;
  logic        aw_full;
  logic        next_aw_full;
  logic [31:0] w_data;
  logic [31:0] next_w_data;
  logic [3:0]  w_strb;
  logic [3:0]  next_w_strb;
  logic        w_full;
  logic        next_w_full;
  logic        bvalid;
  logic        next_bvalid;
  logic [1:0]  bresp;
  logic [1:0]  next_bresp;
  logic        rvalid;
  logic        next_rvalid;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [1:0]  rresp;
  logic [1:0]  next_rresp;
  logic        ext_meta;
  logic        ext_sync;
  logic        gh_meta;
  logic        gh_sync;
  logic        gl_meta;
  logic        gl_sync;
  logic        out_high;
  logic        next_out_high;
  logic        out_low;
  logic        next_out_low;
  logic        sync_out;

  // ==========================================================
  // pin synchronisers
  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      gh_meta  <= 1'b0;
      gh_sync  <= 1'b0;
      gl_meta  <= 1'b0;
      gl_sync  <= 1'b0;
    end
    else
    begin
      ext_meta <= EXT_PERIOD_RESET;
      ext_sync <= ext_meta;
      gh_meta  <= GPIO_HIGH_OUT;
      gh_sync  <= gh_meta;
      gl_meta  <= GPIO_LOW_OUT;
      gl_sync  <= gl_meta;
    end
  end

  // ==========================================================
  // time base
  assign tbi.enable     = tbctl[`PWMOS_BIT_ENABLE];
  assign tbi.ext_rst_en = tbctl[`PWMOS_BIT_EXT_RST_EN];
  assign tbi.ext_rst    = ext_sync;
  assign tbi.period     = period;
  assign tbi.duty       = duty;

  pwmos_timebase u_timebase
  (
    .clk   (SYS_CLK),
    .rst_n (RESET_N),
    .tb    (tbi)
  );

  // ==========================================================
  // axi4-lite slave; write response after both address and data are held
  function automatic pwmos_word_t merge(input pwmos_word_t old, input logic [31:0] d,
                                        input logic [3:0] s);
    pwmos_word_t r;
    r = old;
    if (s[0])
      r[7:0] = d[7:0];
    if (s[1])
      r[15:8] = d[15:8];
    return r;
  endfunction

  always_comb
  begin
    next_aw_addr = aw_addr;
    next_aw_full = aw_full;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_w_full  = w_full;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_ioctl   = ioctl;
    next_tbctl   = tbctl;
    next_period  = period;
    next_duty    = duty;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    if (S_AXI_AWVALID && S_AXI_AWREADY)
    begin
      next_aw_addr = S_AXI_AWADDR;
      next_aw_full = 1'b1;
    end
    if (S_AXI_WVALID && S_AXI_WREADY)
    begin
      next_w_data = S_AXI_WDATA;
      next_w_strb = S_AXI_WSTRB;
      next_w_full = 1'b1;
    end
    if (bvalid && S_AXI_BREADY)
      next_bvalid = 1'b0;
    if (aw_full && w_full && !bvalid)
    begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = `PWMOS_RESP_OKAY;
      unique case (aw_addr)
        `PWMOS_ADDR_IOCTL:  next_ioctl  = merge(ioctl, w_data, w_strb);
        `PWMOS_ADDR_TBCTL:  next_tbctl  = merge(tbctl, w_data, w_strb);
        `PWMOS_ADDR_PERIOD: next_period = merge(period, w_data, w_strb);
        `PWMOS_ADDR_DUTY:   next_duty   = merge(duty, w_data, w_strb);
        default:            next_bresp  = `PWMOS_RESP_SLVERR;
      endcase
    end
    if (rvalid && S_AXI_RREADY)
      next_rvalid = 1'b0;
    if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      next_rvalid = 1'b1;
      next_rresp  = `PWMOS_RESP_OKAY;
      unique case (S_AXI_ARADDR)
        `PWMOS_ADDR_IOCTL:  next_rdata = {16'h0000, ioctl};
        // running flag is the time base's enable input passed back, a copy of tbctl bit 15
        `PWMOS_ADDR_TBCTL:  next_rdata = {16'h0000, tbctl[15], tbi.running, tbctl[13:0]};
        `PWMOS_ADDR_PERIOD: next_rdata = {16'h0000, period};
        `PWMOS_ADDR_DUTY:   next_rdata = {16'h0000, duty};
        default:
        begin
          next_rdata = 32'h00000000;
          next_rresp = `PWMOS_RESP_SLVERR;
        end
      endcase
    end
  end

  assign S_AXI_AWREADY = !aw_full;
  assign S_AXI_WREADY  = !w_full;
  assign S_AXI_ARREADY = !rvalid;
  assign S_AXI_BVALID  = bvalid;
  assign S_AXI_BRESP   = bresp;
  assign S_AXI_RVALID  = rvalid;
  assign S_AXI_RDATA   = rdata;
  assign S_AXI_RRESP   = rresp;

  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      aw_addr <= 4'h0;
      aw_full <= 1'b0;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
      w_full  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= 2'b00;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= 2'b00;
      ioctl   <= `PWMOS_IOCTL_RESET;
      tbctl   <= `PWMOS_TBCTL_RESET;
      period  <= `PWMOS_PERIOD_RESET;
      duty    <= `PWMOS_DUTY_RESET;
    end
    else
    begin
      aw_addr <= next_aw_addr;
      aw_full <= next_aw_full;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      w_full  <= next_w_full;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
      ioctl   <= next_ioctl;
      tbctl   <= next_tbctl;
      period  <= next_period;
      duty    <= next_duty;
    end
  end

  // ==========================================================
  // output stage; a stopped module drives its pwm-owned pins low, or to the override level where an override bit is set
  always_comb
  begin
    next_out_high = tbi.wave;
    next_out_low  = tbi.enable & ~tbi.wave;
    if (ioctl[`PWMOS_BIT_HIGH_OVR])
      next_out_high = ioctl[`PWMOS_BIT_OVR_HIGH];
    if (ioctl[`PWMOS_BIT_LOW_OVR])
      next_out_low = ioctl[`PWMOS_BIT_OVR_LOW];
    if (!ioctl[`PWMOS_BIT_HIGH_OWNER])
      next_out_high = gh_sync;
    if (!ioctl[`PWMOS_BIT_LOW_OWNER])
      next_out_low = gl_sync;
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      out_high <= 1'b0;
      out_low  <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      out_high <= next_out_high;
      out_low  <= next_out_low;
      sync_out <= tbi.sync_pulse;
    end
  end

  assign PWM_HIGH_OUTPUT       = out_high;
  assign PWM_LOW_OUTPUT        = out_low;
  assign SECONDARY_SYNC_OUTPUT = sync_out;
endmodule

// >>> test/pwmos_properties.sv
// port assertions for the pwm output stage
`timescale 1ns/1ps
module pwmos_properties
(
  input wire logic        SYS_CLK,
  input wire logic        RESET_N,
  input wire logic [3:0]  S_AXI_AWADDR,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic        S_AXI_BVALID,
  input wire logic        GPIO_HIGH_OUT,
  input wire logic        PWM_HIGH_OUTPUT,
  input wire logic        PWM_LOW_OUTPUT,
  input wire logic        SECONDARY_SYNC_OUTPUT
);
  // ====================
  // shadow of control words; age lets the pin latency settle first
  logic        wr;
  logic [15:0] io;
  logic [15:0] next_io;
  logic        en;
  logic        next_en;
  logic [3:0]  age;
  logic [3:0]  next_age;
  assign wr = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  always_comb
  begin
    next_io  = (wr && S_AXI_AWADDR == 4'h0) ? S_AXI_WDATA[15:0] : io;
    next_en  = (wr && S_AXI_AWADDR == 4'h4) ? S_AXI_WDATA[15] : en;
    next_age = wr ? 4'h0 : age + {3'h0, age != 4'hF};
  end
  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      io  <= 16'h0000;
      en  <= 1'b0;
      age <= 4'h0;
    end
    else
    begin
      io  <= next_io;
      en  <= next_en;
      age <= next_age;
    end
  end
  // ====================
  // assertions
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  // both halves are held for one cycle before the response is raised
  a_write_answer: assert property (wr |=> !S_AXI_AWREADY ##1 S_AXI_BVALID)
    else $error("late write answer");
  a_gpio_high: assert property (age > 4'h2 && !io[15] && $stable(GPIO_HIGH_OUT) &&
    $past(GPIO_HIGH_OUT, 4) == GPIO_HIGH_OUT |-> PWM_HIGH_OUTPUT == GPIO_HIGH_OUT)
    else $error("high pin not gpio");
  a_high_forced: assert property (age > 4'h2 && io[15] && io[9]
    |-> PWM_HIGH_OUTPUT == io[1]) else $error("high override wrong");
  a_low_forced: assert property (age > 4'h2 && io[14] && io[8]
    |-> PWM_LOW_OUTPUT == io[0]) else $error("low override wrong");
  a_stopped_low: assert property (age > 4'h2 && !en && io[15] && !io[9]
    |-> !PWM_HIGH_OUTPUT) else $error("stopped pin high");
  a_quiet_stop: assert property (age > 4'h8 && !en
    |-> !SECONDARY_SYNC_OUTPUT) else $error("sync while stopped");
  a_sync_width: assert property ($rose(SECONDARY_SYNC_OUTPUT)
    |-> SECONDARY_SYNC_OUTPUT[*5] ##1 !SECONDARY_SYNC_OUTPUT) else $error("sync width");
  a_sync_gap: assert property ($fell(SECONDARY_SYNC_OUTPUT)
    |-> !SECONDARY_SYNC_OUTPUT[*5]) else $error("sync too soon");
endmodule
bind pwmos_top pwmos_properties chk_u
(
  .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .S_AXI_AWADDR(S_AXI_AWADDR),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
  .GPIO_HIGH_OUT(GPIO_HIGH_OUT), .PWM_HIGH_OUTPUT(PWM_HIGH_OUTPUT),
  .PWM_LOW_OUTPUT(PWM_LOW_OUTPUT), .SECONDARY_SYNC_OUTPUT(SECONDARY_SYNC_OUTPUT)
);

// >>> test/pwmos_slave_model.sv
// slave pwm device that locks its time base to the sync output
`timescale 1ns/1ps
module pwmos_slave_model
(
  input wire logic         clk,
  input wire logic         sync_in,
  output logic      [15:0] period_seen,
  output logic      [3:0]  width_seen
);
  logic [15:0] count;
  logic        last;
  // restart the local count on each sync edge, as a locked slave would
  always @(posedge clk)
  begin
    last <= sync_in;
    count <= (sync_in && !last) ? 16'h0001 : count + 16'h0001;
    if (sync_in && !last)
      period_seen <= count;
    if (sync_in)
      width_seen <= last ? width_seen + 4'h1 : 4'h1;
  end
endmodule

// >>> test/test_pwm_output_override_and_sync.sv
// self-checking bench for the pwm output stage
`timescale 1ns/1ps
`include "pwmos_defines.svh"
module test_pwm_output_override_and_sync;
  localparam logic [1:0] OK = `PWMOS_RESP_OKAY;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  aw = 4'h0;
  logic [3:0]  ar = 4'h0;
  logic [31:0] wd = 32'h0;
  logic        awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0, ext = 1'b0, gh = 1'b0;
  logic        gl = 1'b0;
  wire         awrdy, wrdy, bv, arrdy, rv, ph, pl, sy;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [15:0] per;
  wire  [3:0]  wid;
  int          failures = 0, samples_checked = 0, cycles = 0;
  pwmos_top dut_u (.SYS_CLK(clk), .RESET_N(rst_n), .S_AXI_AWADDR(aw), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
    .S_AXI_ARADDR(ar), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .EXT_PERIOD_RESET(ext),
    .GPIO_HIGH_OUT(gh), .GPIO_LOW_OUT(gl), .PWM_HIGH_OUTPUT(ph), .PWM_LOW_OUTPUT(pl),
    .SECONDARY_SYNC_OUTPUT(sy));
  pwmos_slave_model slave_u (.clk(clk), .sync_in(sy), .period_seen(per), .width_seen(wid));
  always #10 clk = ~clk;
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      failures = failures + 1;
      close_out();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
  begin
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  // ====================
  // bus master: each channel is released at the edge that takes it
  // no wait limit of its own: only the bench timeout ends a stuck transfer
  task automatic write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
  begin
    @(posedge clk);
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awrdy) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end
    while (!bv);
    br <= 1'b0;
    check({30'h0, bresp}, {30'h0, r});
  end
  endtask
  task automatic read(input logic [3:0] a, output logic [31:0] d, input logic [1:0] r);
  begin
    @(posedge clk);
    ar <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arrdy) arv <= 1'b0;
    end
    while (!rv);
    rr <= 1'b0;
    d = rdata;
    check({30'h0, rresp}, {30'h0, r});
  end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  // waits for the high pin to reach v, then counts the edges it stays there
  task automatic span(input logic v, output int len);
  begin
    len = 0;
    while (ph !== v && len < 99)
    begin
      @(posedge clk);
      len++;
    end
    len = 0;
    while (ph === v && len < 99)
    begin
      @(posedge clk);
      len++;
    end
  end
  endtask
  task automatic close_out();
  begin
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  // ====================
  // tests
  initial
  begin
    logic [31:0] d;
    int hi;
    int lo;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    read(4'h0, d, OK);
    check(d, `PWMOS_IOCTL_RESET);
    read(4'h8, d, OK);
    check(d, `PWMOS_PERIOD_RESET);
    read(4'hC, d, OK);
    check(d, `PWMOS_DUTY_RESET);
    write(4'h2, 32'h0000FFFF, `PWMOS_RESP_SLVERR);
    write(4'h4, 32'h00004000, OK);
    read(4'h4, d, OK);
    check(d, `PWMOS_TBCTL_RESET);
    $display("test registers done");
    gh <= 1'b1;
    gl <= 1'b1;
    write(4'h8, 32'h13, OK);
    write(4'hC, 32'hA, OK);
    write(4'h0, 32'h0301, OK);
    tick(6);
    check({30'h0, ph, pl}, 32'h3);
    write(4'h4, 32'h8000, OK);
    read(4'h4, d, OK);
    check(d, 32'hC000);
    write(4'h0, 32'h0001, OK);
    tick(25);
    write(4'h0, 32'hC001, OK);
    write(4'h0, 32'hC301, OK);
    tick(4);
    check({30'h0, ph, pl}, 32'h1);
    write(4'h0, 32'hC302, OK);
    tick(4);
    check({30'h0, ph, pl}, 32'h2);
    write(4'h0, 32'hC000, OK);
    span(1, hi);
    span(1, hi);
    check(hi, 32'hA);
    check(per, 32'h14);
    check(wid, `PWMOS_SYNC_CYCLES);
    $display("test ownership and override done");
    write(4'h4, 32'h8001, OK);
    span(1, hi);
    ext <= 1'b1;
    span(0, lo);
    ext <= 1'b0;
    check({31'h0, lo < 10}, 32'h1);
    span(1, hi);
    span(0, lo);
    ext <= 1'b1;
    span(1, hi);
    span(0, lo);
    ext <= 1'b0;
    check(lo, 32'hA);
    $display("test external reset done");
    // spare output as sync source: duty set to the sync pulse width
    write(4'hC, `PWMOS_SYNC_CYCLES, OK);
    span(1, hi);
    span(1, hi);
    check(hi, `PWMOS_SYNC_CYCLES);
    $display("test sync substitute done");
    span(1, hi);
    write(4'h4, 32'h0, OK);
    tick(6);
    check({31'h0, ph}, 32'h0);
    read(4'h4, d, OK);
    check(d, 32'h0);
    $display("test stop done");
    close_out();
  end
endmodule
